/* rtl/irq_ctrl_consts.svh */
// Constants for the interrupt control block: register addresses, bit positions, reset values.
// Assumes inclusion by bare name from rtl/.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
`define ADDR_INTCTL 4'h0
`define ADDR_CONVCTL 4'h1
`define ADDR_OPTION 4'h2
`define ADDR_PORT 4'h3
`define ADDR_TRIS 4'h4
`define ADDR_STATE 4'h5
`define BIT_PCF 0
`define BIT_EXF 1
`define BIT_TWF 2
`define BIT_PCE 3
`define BIT_EXE 4
`define BIT_TWE 5
`define BIT_CDE 6
`define BIT_GIE 7
`define BIT_CDF 1
`define BIT_EDGE 6
`define RST_INTCTL 8'h00
`define RST_OPTION 8'h40
`define RST_TRIS 4'hf
`define TIMER_TOP 8'hff
`define IRQ_VECTOR 13'h0004
`endif

/* rtl/irq_ctrl_pkg.sv */
// Types shared by the interrupt control block.
// Assumes nothing of its surroundings.
package irq_ctrl_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
  typedef struct packed {
    logic timerTick;
    logic [7:0] timerCount;
    logic convDone;
    logic extPin;
    logic [3:0] changePins;
  } events_s;
  typedef struct packed {
    logic irqTake;
    logic retIrq;
    logic sleepEnter;
  } core_s;
  typedef enum logic [1:0] {RUN, SLEEP, WAKE} pwr_e;
  typedef struct packed {
    logic [7:0] intCtl;
    logic convFlag;
    logic [7:0] option;
    logic [3:0] tris;
    logic [3:0] pinLatch;
    logic extPrev;
    logic [7:0] rdata;
    logic wakeVector;
    logic [12:0] vector;
    pwr_e pwr;
  } state_s;
endpackage

/* rtl/mcu_interrupt_control.sv */
// Interrupt logic of a small microcontroller with four event sources and sleep wake-up.
// Assumes the core pulses take, return and sleep strobes in the instruction-cycle clock.
//
// Summary of operation
// - Source flags set on their event whatever the masks or global enable.
// - Return-from-interrupt sets the global enable again.
// - External pin edge rising when edge select is 1, falling when 0.
// - Valid external edge sets ext pin flag, interrupt control bit 1.
// - External pin enable bit 4 at 0 blocks its interrupt.
// - External pin wakes from sleep if its enable was set before sleep.
// - After wake-up, vector taken only when global enable is 1.
// - Timer wrap from ff to 00 sets timer flag, bit 2.
// - Timer enable bit 5 at 0 masks the timer interrupt.
// - Timer interrupt never wakes the device from sleep.
// - Each input change pin compared with its latch every cycle.
// - Mismatches ORed together set port change flag, bit 0.
// - Change pins configured as output take no part in the comparison.
// - Port change interrupt wakes the device from sleep.
// - Port read refreshes latches; cleared port flag then stays clear.
// - Port change enable bit 3 at 0 stops its interrupt.
// - Conversion done sets converter control bit 1, not interrupt control.
// - Conversion enable bit 6 at 0 masks that interrupt.
// - Flags stay set until software clears them.
// - Global enable 1 allows unmasked interrupts, 0 disables all.
// - Accepted interrupt clears global enable and loads vector 0004.
// - Any reset clears the global enable.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module mcu_interrupt_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire irq_ctrl_pkg::bus_req_s busReq,
  output logic [7:0] rdata,
  input wire irq_ctrl_pkg::events_s events,
  input wire irq_ctrl_pkg::core_s core,
  output logic irqRequest,
  output logic wakeUp,
  output logic wakeToVector,
  output logic [12:0] vectorAddr,
  output logic sleeping
);
  import irq_ctrl_pkg::*;

  state_s st_r;
  state_s st_nxt;
  logic rstSafe_n;
  logic [1:0] rstSync_r;
  logic [3:0] mismatch;
  logic extEdge;
  logic timerWrap;
  logic pending;
  logic wakeSrc;

  // ==========================================
  // Reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSafe_n = rstSync_r[1];

  function automatic logic bitsel(input logic [7:0] v, input int unsigned i);
    bitsel = v[i[2:0]];
  endfunction

  // ==========================================
  // Event detection
  always_comb begin
    // Output-configured pins (tris 0) are excluded from the comparison
    mismatch = (events.changePins ^ st_r.pinLatch) & st_r.tris;
    extEdge = bitsel(st_r.option, `BIT_EDGE) ? (events.extPin & ~st_r.extPrev)
                                             : (~events.extPin & st_r.extPrev);
    // Timer is stopped in sleep, so it cannot wake the device
    timerWrap = events.timerTick && events.timerCount == `TIMER_TOP && st_r.pwr != SLEEP;
    pending = (st_r.intCtl[`BIT_EXF] & st_r.intCtl[`BIT_EXE])
            | (st_r.intCtl[`BIT_TWF] & st_r.intCtl[`BIT_TWE])
            | (st_r.intCtl[`BIT_PCF] & st_r.intCtl[`BIT_PCE])
            | (st_r.convFlag & st_r.intCtl[`BIT_CDE]);
    // Wake uses enables only; the global enable only picks the branch
    wakeSrc = (st_r.intCtl[`BIT_EXF] & st_r.intCtl[`BIT_EXE])
            | (st_r.intCtl[`BIT_PCF] & st_r.intCtl[`BIT_PCE]);
  end

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    st_nxt.wakeVector = 1'b0;
    st_nxt.extPrev = events.extPin;
    if (busReq.wr) begin
      case (busReq.addr)
        `ADDR_INTCTL: st_nxt.intCtl = busReq.wdata;
        `ADDR_CONVCTL: st_nxt.convFlag = busReq.wdata[`BIT_CDF];
        `ADDR_OPTION: st_nxt.option = busReq.wdata;
        `ADDR_TRIS: st_nxt.tris = busReq.wdata[3:0];
        default: ;
      endcase
    end
    if (busReq.rd) begin
      case (busReq.addr)
        `ADDR_INTCTL: st_nxt.rdata = st_r.intCtl;
        `ADDR_CONVCTL: st_nxt.rdata = {6'h00, st_r.convFlag, 1'b0};
        `ADDR_OPTION: st_nxt.rdata = st_r.option;
        `ADDR_PORT: begin
          st_nxt.rdata = {events.changePins, 4'h0};
          st_nxt.pinLatch = events.changePins;
        end
        `ADDR_TRIS: st_nxt.rdata = {4'h0, st_r.tris};
        `ADDR_STATE: st_nxt.rdata = {5'h00, irqRequest, st_r.pwr};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (core.retIrq) begin
      st_nxt.intCtl[`BIT_GIE] = 1'b1;
    end
    if (core.irqTake && irqRequest) begin
      st_nxt.intCtl[`BIT_GIE] = 1'b0;
      st_nxt.vector = `IRQ_VECTOR;
    end
    // Sets follow writes so an event in a clearing cycle survives
    if (extEdge) begin
      st_nxt.intCtl[`BIT_EXF] = 1'b1;
    end
    if (timerWrap) begin
      st_nxt.intCtl[`BIT_TWF] = 1'b1;
    end
    if (|mismatch) begin
      st_nxt.intCtl[`BIT_PCF] = 1'b1;
    end
    if (events.convDone) begin
      st_nxt.convFlag = 1'b1;
    end
    case (st_r.pwr)
      RUN: if (core.sleepEnter) st_nxt.pwr = SLEEP;
      SLEEP: if (wakeSrc) st_nxt.pwr = WAKE;
      WAKE: begin
        st_nxt.pwr = RUN;
        st_nxt.wakeVector = st_r.intCtl[`BIT_GIE];
      end
      default: st_nxt.pwr = RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSafe_n) begin
    if (!rstSafe_n) begin
      st_r.intCtl <= `RST_INTCTL;
      st_r.convFlag <= 1'b0;
      st_r.option <= `RST_OPTION;
      st_r.tris <= `RST_TRIS;
      st_r.pinLatch <= 4'h0;
      st_r.extPrev <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.wakeVector <= 1'b0;
      st_r.vector <= `IRQ_VECTOR;
      st_r.pwr <= RUN;
    end else if (clkEn) begin
      st_r.intCtl <= st_nxt.intCtl;
      st_r.convFlag <= st_nxt.convFlag;
      st_r.option <= st_nxt.option;
      st_r.tris <= st_nxt.tris;
      st_r.pinLatch <= st_nxt.pinLatch;
      st_r.extPrev <= st_nxt.extPrev;
      st_r.rdata <= st_nxt.rdata;
      st_r.wakeVector <= st_nxt.wakeVector;
      st_r.vector <= st_nxt.vector;
      st_r.pwr <= st_nxt.pwr;
    end
  end

  // ==========================================
  // Outputs
  assign irqRequest = st_r.intCtl[`BIT_GIE] & pending;
  assign rdata = st_r.rdata;
  assign wakeUp = st_r.pwr == WAKE;
  assign wakeToVector = st_r.wakeVector;
  assign vectorAddr = st_r.vector;
  assign sleeping = st_r.pwr == SLEEP;

  // ==========================================
  // Checks
  sequence takeSeq;
    clkEn && core.irqTake && irqRequest;
  endsequence
  sequence gieOffSeq;
    !st_r.intCtl[`BIT_GIE];
  endsequence

  ext_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && extEdge |=> st_r.intCtl[`BIT_EXF]) else $error("ext flag not set");
  timer_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && timerWrap |=> st_r.intCtl[`BIT_TWF]) else $error("timer flag not set");
  port_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && (|mismatch) |=> st_r.intCtl[`BIT_PCF]) else $error("port flag not set");
  conv_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && events.convDone |=> st_r.convFlag) else $error("conversion flag not set");
  take_clears_gie_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    takeSeq ##0 !core.retIrq |=> gieOffSeq and (vectorAddr == `IRQ_VECTOR)) else $error("take did not clear enable");
  return_sets_gie_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && core.retIrq && !core.irqTake |=> st_r.intCtl[`BIT_GIE]) else $error("return did not set enable");
  gie_gates_req_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    !st_r.intCtl[`BIT_GIE] |-> !irqRequest) else $error("request while disabled");
  ext_mask_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    !st_r.intCtl[`BIT_EXE] && !st_r.intCtl[`BIT_TWF] && !st_r.intCtl[`BIT_PCF] && !st_r.convFlag |-> !irqRequest)
    else $error("masked ext pin requested");
  wake_branch_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && wakeUp |=> wakeToVector == $past(st_r.intCtl[`BIT_GIE])) else $error("wake branch wrong");
  flag_holds_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && st_r.intCtl[`BIT_TWF] && !(busReq.wr && busReq.addr == `ADDR_INTCTL) |=> st_r.intCtl[`BIT_TWF])
    else $error("timer flag dropped");

  // ==========================================
  // Wake-up flow
  // Each step of a sleep period is a sequence so the checks read like the flow
  sequence runEnterSeq;
    clkEn && st_r.pwr == RUN && core.sleepEnter;
  endsequence
  sequence asleepArmedSeq;
    clkEn && st_r.pwr == SLEEP && wakeSrc;
  endsequence
  sequence asleepIdleSeq;
    clkEn && st_r.pwr == SLEEP && !wakeSrc;
  endsequence
  sequence wakeStepSeq;
    clkEn && st_r.pwr == WAKE;
  endsequence
  sequence backToRunSeq;
    !sleeping && !wakeUp;
  endsequence

  sleep_enter_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    runEnterSeq |=> sleeping)
    else $error("sleep not entered");

  armed_wake_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    asleepArmedSeq |=> wakeUp)
    else $error("armed source did not wake");

  port_wake_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && sleeping && st_r.intCtl[`BIT_PCF] && st_r.intCtl[`BIT_PCE] |=> wakeUp)
    else $error("port change did not wake");

  idle_sleep_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    asleepIdleSeq |=> sleeping)
    else $error("woke with no armed source");

  no_sleep_wrap_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    st_r.pwr == SLEEP |-> !timerWrap)
    else $error("timer wrapped in sleep");

  wake_leaves_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    wakeStepSeq |=> backToRunSeq)
    else $error("wake did not return to run");

  wake_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && wakeToVector |=> !wakeToVector)
    else $error("branch pulse too long");

  // ==========================================
  // Flag capture and hold
  // Holds exclude register writes, since software owns the clear
  rise_edge_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && st_r.option[`BIT_EDGE] && events.extPin && !st_r.extPrev |=> st_r.intCtl[`BIT_EXF])
    else $error("rising edge missed");

  fall_edge_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && !st_r.option[`BIT_EDGE] && !events.extPin && st_r.extPrev |=> st_r.intCtl[`BIT_EXF])
    else $error("falling edge missed");

  quiet_pin_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && !extEdge && !busReq.wr |=> st_r.intCtl[`BIT_EXF] == $past(st_r.intCtl[`BIT_EXF]))
    else $error("ext flag moved without edge");

  no_wrap_flag_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && !timerWrap && !busReq.wr |=> st_r.intCtl[`BIT_TWF] == $past(st_r.intCtl[`BIT_TWF]))
    else $error("timer flag moved without wrap");

  ext_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && st_r.intCtl[`BIT_EXF] && !(busReq.wr && busReq.addr == `ADDR_INTCTL) |=> st_r.intCtl[`BIT_EXF])
    else $error("ext flag dropped");

  port_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && st_r.intCtl[`BIT_PCF] && !(busReq.wr && busReq.addr == `ADDR_INTCTL) |=> st_r.intCtl[`BIT_PCF])
    else $error("port flag dropped");

  conv_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && st_r.convFlag && !(busReq.wr && busReq.addr == `ADDR_CONVCTL) |=> st_r.convFlag)
    else $error("conversion flag dropped");

  out_pins_ignored_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    st_r.tris == 4'h0 |-> mismatch == 4'h0)
    else $error("output pin compared");

  port_read_latch_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.rd && busReq.addr == `ADDR_PORT |=> st_r.pinLatch == $past(events.changePins))
    else $error("port read did not refresh latch");

  // ==========================================
  // Request and acceptance
  // The request is combinational, so the request checks hold in the same cycle; the take checks look one cycle on
  masks_block_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    !st_r.intCtl[`BIT_EXE] && !st_r.intCtl[`BIT_TWE] && !st_r.intCtl[`BIT_PCE] && !st_r.intCtl[`BIT_CDE]
      |-> !irqRequest)
    else $error("request with all sources masked");

  armed_req_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    st_r.intCtl[`BIT_GIE] && st_r.intCtl[`BIT_EXF] && st_r.intCtl[`BIT_EXE] |-> irqRequest)
    else $error("armed source not requested");

  take_idle_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && core.irqTake && !irqRequest && !core.retIrq && !(busReq.wr && busReq.addr == `ADDR_INTCTL)
      |=> st_r.intCtl[`BIT_GIE] == $past(st_r.intCtl[`BIT_GIE]))
    else $error("take without request acted");

  take_wins_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && core.irqTake && core.retIrq && irqRequest |=> !st_r.intCtl[`BIT_GIE])
    else $error("return beat accepted take");

  vector_fixed_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    vectorAddr == `IRQ_VECTOR)
    else $error("vector address wrong");

  // ==========================================
  // Register port
  rd_intctl_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.rd && busReq.addr == `ADDR_INTCTL |=> rdata == $past(st_r.intCtl))
    else $error("control read wrong");

  rd_port_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.rd && busReq.addr == `ADDR_PORT |=> rdata == {$past(events.changePins), 4'h0})
    else $error("port read wrong");

  rd_state_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.rd && busReq.addr == `ADDR_STATE |=> rdata == {5'h00, $past(irqRequest), $past(st_r.pwr)})
    else $error("status read wrong");

  rd_idle_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && !busReq.rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  wr_option_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.wr && busReq.addr == `ADDR_OPTION |=> st_r.option == $past(busReq.wdata))
    else $error("option write lost");

  wr_tris_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.wr && busReq.addr == `ADDR_TRIS |=> st_r.tris == $past(busReq.wdata[3:0]))
    else $error("direction write lost");

  wr_conv_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    clkEn && busReq.wr && busReq.addr == `ADDR_CONVCTL && !events.convDone
      |=> st_r.convFlag == $past(busReq.wdata[`BIT_CDF]))
    else $error("conversion flag write lost");

  // A low enable must leave every field of st_r untouched
  freeze_a: assert property (@(posedge sys_clk) disable iff (!rstSafe_n)
    !clkEn |=> $stable(st_r))
    else $error("state moved while frozen");
endmodule
`default_nettype wire

/* bench/event_source.sv */
// Model of the peripheral event sources: timer, converter and pins.
// Assumes the bench drives its inputs by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic conv,
  input wire logic extLvl,
  input wire logic [3:0] pins,
  input wire logic sleeping,
  output var irq_ctrl_pkg::events_s events
);
  import irq_ctrl_pkg::*;
  logic [7:0] count_r;
  // Timer is shut off in sleep, so it never wraps there
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) count_r <= 8'h00;
    else if (tick && !sleeping) count_r <= count_r + 8'h01;
  end
  assign events = '{tick && !sleeping, count_r, conv, extLvl, pins};
endmodule
`default_nettype wire

/* bench/mcu_interrupt_control_tb.sv */
// Self-checking bench for the interrupt control block.
// Assumes the design files and the event source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module mcu_interrupt_control_tb;
  import irq_ctrl_pkg::*;
  logic sys_clk, rst_n, clkEn, tick, conv, extLvl, rdv;
  logic [3:0] pins, p;
  logic [31:0] seed;
  bus_req_s busReq;
  core_s core;
  events_s events;
  logic [7:0] rdata;
  logic irqRequest, wakeUp, wakeToVector, sleeping;
  logic [12:0] vectorAddr;
  logic [7:0] expQ[$];
  int numErrors, checked;
  mcu_interrupt_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .busReq(busReq), .rdata(rdata),
    .events(events), .core(core), .irqRequest(irqRequest), .wakeUp(wakeUp), .wakeToVector(wakeToVector),
    .vectorAddr(vectorAddr), .sleeping(sleeping));
  event_source src (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick), .conv(conv), .extLvl(extLvl), .pins(pins),
    .sleeping(sleeping), .events(events));
  // ==========================================
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk);
    busReq <= '{a, d, w, !w};
    if (!w && clkEn) expQ.push_back(d);
    @(posedge sys_clk);
    busReq <= '0;
  endtask
  task automatic pulse(input core_s c);
    @(posedge sys_clk);
    core <= c;
    @(posedge sys_clk);
    core <= '0;
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read data stand in the cycle after the strobe only
  always @(posedge sys_clk) rdv <= busReq.rd & clkEn;
  always @(negedge sys_clk) if (rdv === 1'b1) chk(rdata, expQ.pop_front(), "rdata");
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    numErrors++;
    end_sim();
  end
  // ==========================================
  // Scenarios
  initial begin
    {rst_n, tick, conv, extLvl, pins, rdv} = '0;
    {clkEn, busReq, core, seed} = {1'b1, 14'h0, 3'h0, 32'hd51e};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1;
    repeat (4) @(posedge sys_clk);
    bus(`ADDR_INTCTL, `RST_INTCTL, 0);
    bus(`ADDR_OPTION, `RST_OPTION, 0);
    bus(4'h7, 8'h00, 0);
    extLvl <= 1;
    bus(`ADDR_INTCTL, 8'h02, 0);
    bus(`ADDR_OPTION, 8'h00, 1);
    bus(`ADDR_INTCTL, 8'h00, 1);
    extLvl <= 0;
    bus(`ADDR_INTCTL, 8'h02, 0);
    bus(`ADDR_INTCTL, 8'h00, 1);
    conv <= 1;
    @(posedge sys_clk) conv <= 0;
    bus(`ADDR_CONVCTL, 8'h02, 0);
    bus(`ADDR_INTCTL, 8'h00, 0);
    seed = xs(seed);
    p = seed[3:0] | 4'h1;
    pins <= p;
    bus(`ADDR_INTCTL, 8'h01, 0);
    bus(`ADDR_PORT, {p, 4'h0}, 0);
    bus(`ADDR_INTCTL, 8'h00, 1);
    bus(`ADDR_INTCTL, 8'h00, 0);
    bus(`ADDR_TRIS, 8'h00, 1);
    pins <= ~p;
    bus(`ADDR_INTCTL, 8'h00, 0);
    pins <= p;
    bus(`ADDR_TRIS, 8'h0f, 1);
    tick <= 1;
    repeat (256) @(posedge sys_clk);
    tick <= 0;
    bus(`ADDR_INTCTL, 8'h04, 0);
    bus(`ADDR_INTCTL, 8'ha4, 1);
    look(1);
    chk(irqRequest, 1, "irqRequest");
    bus(`ADDR_INTCTL, 8'h84, 1);
    look(1);
    chk(irqRequest, 0, "irqRequest");
    bus(`ADDR_INTCTL, 8'ha4, 1);
    pulse('{1'b1, 1'b0, 1'b0});
    bus(`ADDR_INTCTL, 8'h24, 0);
    chk(vectorAddr, `IRQ_VECTOR, "vectorAddr");
    pulse('{1'b0, 1'b1, 1'b0});
    bus(`ADDR_INTCTL, 8'ha4, 0);
    bus(`ADDR_OPTION, 8'h40, 1);
    bus(`ADDR_INTCTL, 8'h90, 1);
    pulse('{1'b0, 1'b0, 1'b1});
    look(1);
    chk(sleeping, 1, "sleeping");
    @(posedge sys_clk) extLvl <= 1;
    for (int i = 0; i < 8 && wakeUp !== 1'b1; i++) look(1);
    chk(wakeUp, 1, "wakeUp");
    look(1);
    chk(wakeToVector, 1, "wakeToVector");
    bus(`ADDR_INTCTL, 8'h08, 1);
    pulse('{1'b0, 1'b0, 1'b1});
    @(posedge sys_clk) pins <= ~p;
    for (int i = 0; i < 8 && wakeUp !== 1'b1; i++) look(1);
    chk(wakeUp, 1, "wakeUp");
    look(1);
    chk(wakeToVector, 0, "wakeToVector");
    bus(`ADDR_PORT, {~p, 4'h0}, 0);
    bus(`ADDR_INTCTL, 8'h82, 1);
    look(1);
    chk(irqRequest, 0, "irqRequest");
    bus(`ADDR_INTCTL, 8'hc0, 1);
    look(1);
    chk(irqRequest, 1, "irqRequest");
    bus(`ADDR_CONVCTL, 8'h00, 1);
    look(1);
    chk(irqRequest, 0, "irqRequest");
    bus(`ADDR_INTCTL, 8'h00, 1);
    clkEn <= 0;
    bus(`ADDR_INTCTL, 8'hff, 1);
    clkEn <= 1;
    bus(`ADDR_INTCTL, 8'h00, 0);
    look(2);
    end_sim();
  end
endmodule
`default_nettype wire
